// file: mppc_pkg.sv
// package for the multipurpose pin and power configuration bank
// assumes a single mclk domain and the plain register port of the top module
package mppc_pkg;

  localparam int MPPC_PINS = 12;
  localparam logic [11:0] MPPC_OFF_PIN_LO = 12'h820;
  localparam logic [11:0] MPPC_OFF_PIN_HI = 12'h821;
  localparam logic [11:0] MPPC_OFF_AUXPWR = 12'h822;
  localparam logic [11:0] MPPC_OFF_AUXEN = 12'h824;
  localparam logic [11:0] MPPC_OFF_OSC = 12'h826;
  localparam logic [11:0] MPPC_OFF_DACSET = 12'h827;

  localparam logic [23:0] MPPC_RST_PIN = 24'h000000;
  localparam logic [15:0] MPPC_RST_16 = 16'h0000;

  // writable bit masks; reserved bits are dropped on write and read as zero
  localparam logic [15:0] MPPC_MASK_AUXPWR = 16'h03EF;
  localparam logic [15:0] MPPC_MASK_AUXEN = 16'h8000;
  localparam logic [15:0] MPPC_MASK_OSC = 16'h0004;
  localparam logic [15:0] MPPC_MASK_DACSET = 16'h0003;

  localparam int MPPC_FIL_LSB = 8;
  localparam int MPPC_ADCPD_BIT = 7;
  localparam int MPPC_REFERENCE_BUFFER_POWER_DOWN_BIT = 6;
  localparam int MPPC_REFERENCE_POWER_DOWN_BIT = 5;
  localparam int MPPC_AUXEN_BIT = 15;
  localparam int MPPC_OSC_BIT = 2;
  localparam logic [1:0] MPPC_DAC_INIT = 2'h1;

  // filter select codes
  localparam logic [1:0] MPPC_FIL_HYS4 = 2'h0;
  localparam logic [1:0] MPPC_FIL_HYS5 = 2'h1;
  localparam logic [1:0] MPPC_FIL_BYPASS = 2'h2;
  localparam logic [1:0] MPPC_FIL_NOLPF = 2'h3;

  // debounce: input must stay changed this many mclk cycles plus one (16) before the output follows
  localparam logic [3:0] MPPC_DEB_CYCLES = 4'hF;

  typedef struct packed {
    logic [11:0] addr;
    logic [23:0] wdata;
    logic wr;
    logic rd;
  } mppc_req_t;

  typedef struct packed {
    logic main_adc_power_down;
    logic reference_buffer_power_down;
    logic reference_power_down;
    logic [3:0] dac_power_down;
    logic aux_converter_on;
    logic oscillator_off;
    logic lpf_enable;
    logic hys_enable;
    logic hys_wide;
    logic dac_init;
  } mppc_pwr_t;

endpackage

// file: mppc_debounce.sv
// debounce filter for one synchronised pin input
// assumes the input is already in the mclk domain
`timescale 1ns/1ps
`default_nettype none
module mppc_debounce
  import mppc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);

  typedef struct packed {
    logic [3:0] cnt;
    logic q;
  } mppc_deb_st_t;

  mppc_deb_st_t st_r;
  mppc_deb_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (din == st_r.q) begin
      st_nxt.cnt = 4'h0;
    end else if (st_r.cnt == MPPC_DEB_CYCLES) begin
      st_nxt.q = din;
      st_nxt.cnt = 4'h0;
    end else begin
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule
`default_nettype wire

// file: mppc_pin_cell.sv
// one multipurpose pin: function decode, inversion, drive and input path
// assumes pin_in is asynchronous and core signals are on mclk
`timescale 1ns/1ps
`default_nettype none
module mppc_pin_cell
  import mppc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] pin_function_nibble,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pull_up_en,
  input wire logic core_out,
  input wire logic serial_out,
  input wire logic serial_dir_out,
  output logic core_in,
  output logic serial_in,
  output logic aux_sel
);

  typedef struct packed {
    logic [2:0] sync;
    logic stable;
  } mppc_pc_st_t;

  mppc_pc_st_t st_r;
  mppc_pc_st_t st_nxt;
  logic deb;
  logic inv;
  logic [2:0] fn;
  logic drv;

  assign inv = pin_function_nibble[3];
  assign fn = pin_function_nibble[2:0];

  // an input change counts once the last two stages agree
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync = {st_r.sync[1:0], pin_in};
    if (st_r.sync[2] == st_r.sync[1]) begin
      st_nxt.stable = st_r.sync[2];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  mppc_debounce u_deb (
    .mclk(mclk),
    .reset(reset),
    .din(st_r.stable),
    .dout(deb)
  );

  // reserved and no-function codes fall into default: passive, no drive
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    pull_up_en = 1'b0;
    core_in = 1'b0;
    serial_in = 1'b0;
    aux_sel = 1'b0;
    drv = 1'b0;
    if (pin_function_nibble == 4'hF) begin
      aux_sel = 1'b1;
    end else begin
      case (fn)
        3'h0: begin
          core_in = deb ^ inv;
          pull_up_en = 1'b1;
        end
        3'h1: begin
          core_in = st_r.stable ^ inv;
          pull_up_en = 1'b1;
        end
        3'h2: begin
          drv = core_out ^ inv;
          pin_out = drv;
          pin_oe = 1'b1;
        end
        3'h3: begin
          // open collector: drive low only
          drv = core_out ^ inv;
          pin_out = 1'b0;
          pin_oe = ~drv;
        end
        3'h4: begin
          if (serial_dir_out) begin
            pin_out = serial_out ^ inv;
            pin_oe = 1'b1;
          end else begin
            serial_in = st_r.stable ^ inv;
            pull_up_en = 1'b1;
          end
        end
        default: begin
          pin_oe = 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: mppc_top.sv
// register bank for multipurpose pin functions and converter power control
// assumes a same-clock register master: one-cycle strobes, read data next cycle
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - two 24-bit pin function registers hold twelve nibbles, pins 0-5 low then pins 6-11, ascending from bit 0.
// - each pin nibble steers only its own pin.
// - the top bit of a nibble inverts the pin level on its input or output path.
// - the pull-up is on only for a general input or a serial input.
// - codes 0 to 3 are debounced input, raw input, push-pull output and open-collector output; 5 to 7 do nothing.
// - code 1 bypasses the debounce that code 0 applies, and codes 9 and 8 repeat them inverted.
// - code 4 joins the pin to the serial data port and code 12 does so inverted.
// - code 15 makes an auxiliary converter input, 10 and 11 inverted outputs, 13 and 14 are reserved.
// - filter select 0 gives 4-bit and 1 gives 5-bit hysteresis on a 12-bit level.
// - filter select 2 bypasses filter and hysteresis, 3 bypasses only the low-pass filter.
// - the power control register has filter select at 9:8 and power-downs at 7, 6, 5 and 3:0.
// - the auxiliary converter runs only while bit 15 of its enable register is set.
// - bit 2 of the oscillator register stops the crystal oscillator.
// - writing 01 to the dac setup field starts dac initialisation; other values are reserved.
// - the low-pass filter is on by default once the converter runs, and results are 12 bits padded to 16.
module mppc_top
  import mppc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  input wire logic [11:0] pin_in,
  output logic [11:0] pin_out,
  output logic [11:0] pin_oe,
  output logic [11:0] pull_up_en,
  input wire logic [11:0] core_out,
  input wire logic [11:0] serial_out,
  input wire logic [11:0] serial_dir_out,
  output logic [11:0] core_in,
  output logic [11:0] serial_in,
  output logic [11:0] aux_sel,
  input wire logic [11:0] aux_raw,
  output logic [15:0] aux_result,
  output logic main_adc_power_down,
  output logic reference_buffer_power_down,
  output logic reference_power_down,
  output logic [3:0] dac_power_down,
  output logic aux_converter_on,
  output logic oscillator_off,
  output logic aux_lpf_enable,
  output logic aux_hys_enable,
  output logic aux_hys_wide,
  output logic dac_init_pulse
);

  typedef struct packed {
    logic [23:0] pin_lo;
    logic [23:0] pin_hi;
    logic [15:0] auxpwr;
    logic [15:0] auxen;
    logic [15:0] osc;
    logic [15:0] dacset;
    logic [23:0] rdata;
    logic init_p;
    logic [11:0] aux_lp;
    logic [11:0] aux_held;
  } mppc_st_t;

  mppc_st_t st_r;
  mppc_st_t st_nxt;
  mppc_req_t req;
  mppc_pwr_t pwr;
  logic [47:0] pin_cfg;
  logic [1:0] fil;
  logic [11:0] aux_src;
  logic [11:0] diff;
  logic [11:0] thr;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign pin_cfg = {st_r.pin_hi, st_r.pin_lo};
  assign fil = st_r.auxpwr[MPPC_FIL_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////
  // register file and aux path

  always_comb begin
    st_nxt = st_r;
    st_nxt.init_p = 1'b0;
    st_nxt.rdata = 24'h000000;
    if (req.wr) begin
      case (req.addr)
        MPPC_OFF_PIN_LO: st_nxt.pin_lo = req.wdata;
        MPPC_OFF_PIN_HI: st_nxt.pin_hi = req.wdata;
        MPPC_OFF_AUXPWR: st_nxt.auxpwr = req.wdata[15:0] & MPPC_MASK_AUXPWR;
        MPPC_OFF_AUXEN: st_nxt.auxen = req.wdata[15:0] & MPPC_MASK_AUXEN;
        MPPC_OFF_OSC: st_nxt.osc = req.wdata[15:0] & MPPC_MASK_OSC;
        MPPC_OFF_DACSET: begin
          st_nxt.dacset = req.wdata[15:0] & MPPC_MASK_DACSET;
          st_nxt.init_p = (req.wdata[1:0] == MPPC_DAC_INIT);
        end
        default: st_nxt.dacset = st_r.dacset;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        MPPC_OFF_PIN_LO: st_nxt.rdata = st_r.pin_lo;
        MPPC_OFF_PIN_HI: st_nxt.rdata = st_r.pin_hi;
        MPPC_OFF_AUXPWR: st_nxt.rdata = {8'h00, st_r.auxpwr};
        MPPC_OFF_AUXEN: st_nxt.rdata = {8'h00, st_r.auxen};
        MPPC_OFF_OSC: st_nxt.rdata = {8'h00, st_r.osc};
        MPPC_OFF_DACSET: st_nxt.rdata = {8'h00, st_r.dacset};
        default: st_nxt.rdata = 24'h000000;
      endcase
    end
    // first-order low-pass, one eighth step; cheap and enough to still lsb jitter
    if (!pwr.aux_converter_on) begin
      st_nxt.aux_lp = 12'h000;
      st_nxt.aux_held = 12'h000;
    end else begin
      if (pwr.lpf_enable) begin
        // all operands signed, so a falling input steps down instead of wrapping
        st_nxt.aux_lp = 12'($signed({1'b0, st_r.aux_lp}) + ($signed({1'b0, aux_raw}) - $signed({1'b0, st_r.aux_lp})) / 8);
      end else begin
        st_nxt.aux_lp = aux_raw;
      end
      if (!pwr.hys_enable || diff >= thr) begin
        st_nxt.aux_held = aux_src;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decoded controls

  always_comb begin
    pwr.main_adc_power_down = st_r.auxpwr[MPPC_ADCPD_BIT];
    pwr.reference_buffer_power_down = st_r.auxpwr[MPPC_REFERENCE_BUFFER_POWER_DOWN_BIT];
    pwr.reference_power_down = st_r.auxpwr[MPPC_REFERENCE_POWER_DOWN_BIT];
    pwr.dac_power_down = {st_r.auxpwr[0], st_r.auxpwr[1], st_r.auxpwr[2], st_r.auxpwr[3]};
    pwr.aux_converter_on = st_r.auxen[MPPC_AUXEN_BIT];
    pwr.oscillator_off = st_r.osc[MPPC_OSC_BIT];
    pwr.lpf_enable = pwr.aux_converter_on && (fil == MPPC_FIL_HYS4 || fil == MPPC_FIL_HYS5);
    pwr.hys_enable = (fil != MPPC_FIL_BYPASS);
    pwr.hys_wide = (fil == MPPC_FIL_HYS5);
    pwr.dac_init = st_r.init_p;
  end

  assign aux_src = st_r.aux_lp;
  assign diff = (aux_src > st_r.aux_held) ? aux_src - st_r.aux_held : st_r.aux_held - aux_src;
  assign thr = pwr.hys_wide ? 12'h020 : 12'h010;

  assign main_adc_power_down = pwr.main_adc_power_down;
  assign reference_buffer_power_down = pwr.reference_buffer_power_down;
  assign reference_power_down = pwr.reference_power_down;
  assign dac_power_down = pwr.dac_power_down;
  assign aux_converter_on = pwr.aux_converter_on;
  assign oscillator_off = pwr.oscillator_off;
  assign aux_lpf_enable = pwr.lpf_enable;
  assign aux_hys_enable = pwr.hys_enable;
  assign aux_hys_wide = pwr.hys_wide;
  assign dac_init_pulse = pwr.dac_init;
  assign aux_result = {st_r.aux_held, 4'h0};
  assign reg_rdata = st_r.rdata;

  ////////////////////////////////////////////////////////////////////////
  // pin cells, one per nibble

  genvar g;
  generate
    for (g = 0; g < MPPC_PINS; g++) begin : g_pin
      mppc_pin_cell u_cell (
        .mclk(mclk),
        .reset(reset),
        .pin_function_nibble(pin_cfg[4*g +: 4]),
        .pin_in(pin_in[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .pull_up_en(pull_up_en[g]),
        .core_out(core_out[g]),
        .serial_out(serial_out[g]),
        .serial_dir_out(serial_dir_out[g]),
        .core_in(core_in[g]),
        .serial_in(serial_in[g]),
        .aux_sel(aux_sel[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // assertions

  aux_enable_follows_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_AUXEN) |=> (aux_converter_on == $past(reg_wdata[15])))
    else $error("aux enable does not follow write");
  osc_off_follows_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_OSC) |=> (oscillator_off == $past(reg_wdata[2])))
    else $error("oscillator power-down does not follow write");
  dac_init_pulse_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_DACSET) |=> (dac_init_pulse == ($past(reg_wdata[1:0]) == 2'h1)))
    else $error("dac init pulse wrong");
  dac_init_single_a: assert property (@(posedge mclk) disable iff (reset)
    dac_init_pulse |=> !dac_init_pulse || $past(reg_wr))
    else $error("dac init pulse too long");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && reg_addr == MPPC_OFF_AUXPWR) |=> (reg_rdata[23:10] == 14'h0000 && reg_rdata[4] == 1'b0))
    else $error("reserved bits read non-zero");
  pin_low_read_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_PIN_LO) ##1 (reg_rd && reg_addr == MPPC_OFF_PIN_LO)
    |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("pin register readback wrong");
  pullup_decode_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'h2 || pin_cfg[15:12] == 4'hF) |-> !pull_up_en[3])
    else $error("pull-up on for non-input");
  passive_reserved_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[35:32] inside {4'h5, 4'h6, 4'h7, 4'hD, 4'hE}) |-> !pin_oe[8])
    else $error("reserved code drives pin");
  power_bits_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_AUXPWR) |=> (main_adc_power_down == $past(reg_wdata[7])
    && dac_power_down[0] == $past(reg_wdata[3])))
    else $error("power-down bits wrong");
  bypass_mode_a: assert property (@(posedge mclk) disable iff (reset)
    (fil == MPPC_FIL_BYPASS) |-> (!aux_hys_enable && !aux_lpf_enable))
    else $error("bypass mode not honoured");
  unmapped_read_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && reg_addr == 12'h825) |=> (reg_rdata == 24'h000000))
    else $error("unmapped read non-zero");

  // pin decode checks watch pin 3 and pin 8, the pins the bench sweeps
  push_pull_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'h2) |-> (pin_oe[3] && pin_out[3] == core_out[3]))
    else $error("push-pull output wrong");
  inverted_output_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'hA) |-> (pin_oe[3] && pin_out[3] == !core_out[3]))
    else $error("inverted output wrong");
  open_collector_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'h3) |-> (!pin_out[3] && pin_oe[3] == !core_out[3]))
    else $error("open-collector output wrong");
  inv_open_collector_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'hB) |-> (!pin_out[3] && pin_oe[3] == core_out[3]))
    else $error("inverted open-collector wrong");
  aux_input_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[35:32] == 4'hF) |-> (aux_sel[8] && !pin_oe[8] && !pull_up_en[8]))
    else $error("aux input pin wrong");
  gpio_input_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] inside {4'h0, 4'h1, 4'h8, 4'h9}) |-> (pull_up_en[3] && !pin_oe[3]))
    else $error("gpio input pin wrong");
  serial_input_a: assert property (@(posedge mclk) disable iff (reset)
    (pin_cfg[15:12] == 4'h4 && !serial_dir_out[3]) |-> (pull_up_en[3] && !pin_oe[3]))
    else $error("serial input pin wrong");
  hys_wide_a: assert property (@(posedge mclk) disable iff (reset)
    (fil == MPPC_FIL_HYS5) |-> (aux_hys_enable && aux_hys_wide))
    else $error("wide hysteresis not selected");
  lpf_bypass_a: assert property (@(posedge mclk) disable iff (reset)
    (fil == MPPC_FIL_NOLPF) |-> (aux_hys_enable && !aux_lpf_enable))
    else $error("low-pass bypass not honoured");
  lpf_default_a: assert property (@(posedge mclk) disable iff (reset)
    (aux_converter_on && fil == MPPC_FIL_HYS4) |-> aux_lpf_enable)
    else $error("low-pass filter not on by default");
  result_pad_a: assert property (@(posedge mclk) disable iff (reset)
    aux_result[3:0] == 4'h0)
    else $error("aux result padding non-zero");
  aux_off_clear_a: assert property (@(posedge mclk) disable iff (reset)
    !aux_converter_on |=> (aux_result == 16'h0000))
    else $error("aux result held while converter off");
  ref_bits_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == MPPC_OFF_AUXPWR) |=>
    (reference_buffer_power_down == $past(reg_wdata[6]) && reference_power_down == $past(reg_wdata[5])
    && dac_power_down[3] == $past(reg_wdata[0])))
    else $error("reference or dac power-down bits wrong");
  unmapped_write_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_wr && reg_addr == 12'h823) |=> ($stable(main_adc_power_down) && $stable(aux_converter_on)
    && $stable(oscillator_off) && $stable(dac_power_down)))
    else $error("unmapped write changed a control");
  read_idle_a: assert property (@(posedge mclk) disable iff (reset)
    !reg_rd |=> (reg_rdata == 24'h000000))
    else $error("read data outside read cycle");
  osc_reserved_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && reg_addr == MPPC_OFF_OSC) |=> (reg_rdata[23:3] == 21'h000000 && reg_rdata[1:0] == 2'h0))
    else $error("oscillator reserved bits non-zero");
  dacset_reserved_a: assert property (@(posedge mclk) disable iff (reset)
    (reg_rd && reg_addr == MPPC_OFF_DACSET) |=> (reg_rdata[23:2] == 22'h000000))
    else $error("dac setup reserved bits non-zero");

  aux_on_c: cover property (@(posedge mclk) disable iff (reset) aux_converter_on && aux_lpf_enable);
  dac_init_c: cover property (@(posedge mclk) disable iff (reset) dac_init_pulse);
  pin_drive_c: cover property (@(posedge mclk) disable iff (reset) pin_oe[3] && !pin_out[3]);
  bypass_c: cover property (@(posedge mclk) disable iff (reset) aux_converter_on && fil == MPPC_FIL_BYPASS);

endmodule
`default_nettype wire

// file: tb_mppc_top.sv
// self-checking testbench for the pin function and power control register bank
// assumes mppc_pkg is compiled first; assertions live inside the design files
`timescale 1ns/1ps
`default_nettype none
module tb_mppc_top;
  import mppc_pkg::*;
  logic mclk, reset, reg_wr, reg_rd, main_adc_power_down, reference_buffer_power_down;
  logic reference_power_down, aux_converter_on, oscillator_off, aux_lpf_enable;
  logic aux_hys_enable, aux_hys_wide, dac_init_pulse;
  logic [11:0] reg_addr, pin_in, pin_out, pin_oe, pull_up_en, core_out, serial_out;
  logic [11:0] serial_dir_out, core_in, serial_in, aux_sel, aux_raw;
  logic [23:0] reg_wdata, reg_rdata;
  logic [15:0] aux_result;
  logic [3:0] dac_power_down;
  logic [11:0] addrs [6];
  logic [23:0] masks [6];
  int num_errors = 0;
  int cmp_count = 0;
  //////////////////////////////////////////////////////////////////////////////
  mppc_top DUT (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_up_en(pull_up_en), .core_out(core_out), .serial_out(serial_out),
    .serial_dir_out(serial_dir_out), .core_in(core_in), .serial_in(serial_in), .aux_sel(aux_sel),
    .aux_raw(aux_raw), .aux_result(aux_result), .main_adc_power_down(main_adc_power_down),
    .reference_buffer_power_down(reference_buffer_power_down),
    .reference_power_down(reference_power_down), .dac_power_down(dac_power_down),
    .aux_converter_on(aux_converter_on), .oscillator_off(oscillator_off),
    .aux_lpf_enable(aux_lpf_enable), .aux_hys_enable(aux_hys_enable),
    .aux_hys_wide(aux_hys_wide), .dac_init_pulse(dac_init_pulse));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // write is one strobe cycle; returns right at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [23:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
    @(posedge mclk);
    #1;
    chk("reg_rdata idle", reg_rdata, 24'h000000);
  endtask
  // watchdog: the tests need about 1300 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] c;
    logic inv, is_in, ser, pp, oc;
    int p, sh;
    logic [11:0] a, bit_p;
    addrs = '{MPPC_OFF_PIN_LO, MPPC_OFF_PIN_HI, MPPC_OFF_AUXPWR, MPPC_OFF_AUXEN, MPPC_OFF_OSC,
      MPPC_OFF_DACSET};
    masks = '{24'hFFFFFF, 24'hFFFFFF, 24'h0003EF, 24'h008000, 24'h000004, 24'h000003};
    reset = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 24'h000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pin_in = 12'hFFF;
    core_out = 12'hFFF;
    serial_out = 12'h000;
    serial_dir_out = 12'h000;
    aux_raw = 12'hABC;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    #1;
    chk("pull_up_en", {12'h000, pull_up_en}, 24'h000FFF);
    chk("pin_oe", {12'h000, pin_oe}, 24'h000000);
    // reset values, then reserved bits dropped on write
    for (int i = 0; i < 6; i++) begin
      rd(addrs[i], 24'h000000);
      wr(addrs[i], 24'hFFFFFF);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 24'h000000);
    end
    wr(12'h823, 24'hFFFFFF);
    rd(12'h823, 24'h000000);
    // power-down bits: 7, 6, 5 and dac two at bit 1
    wr(MPPC_OFF_AUXPWR, 24'h0000A2);
    #1;
    chk("main_adc_power_down", {23'h0, main_adc_power_down}, 24'h1);
    chk("reference_buffer_power_down", {23'h0, reference_buffer_power_down}, 24'h0);
    chk("reference_power_down", {23'h0, reference_power_down}, 24'h1);
    chk("dac_power_down", {20'h0, dac_power_down}, 24'h4);
    wr(MPPC_OFF_OSC, 24'h000004);
    #1;
    chk("oscillator_off", {23'h0, oscillator_off}, 24'h1);
    // the low-pass enable only comes on once the converter runs
    wr(MPPC_OFF_AUXPWR, 24'h000000);
    #1;
    chk("aux_lpf_enable off", {23'h0, aux_lpf_enable}, 24'h0);
    wr(MPPC_OFF_AUXEN, 24'h008000);
    #1;
    chk("aux_converter_on", {23'h0, aux_converter_on}, 24'h1);
    for (int f = 0; f < 4; f++) begin
      wr(MPPC_OFF_AUXPWR, 24'(f) << 8);
      #1;
      chk("aux_lpf_enable", {23'h0, aux_lpf_enable}, 24'(f < 2));
      chk("aux_hys_enable", {23'h0, aux_hys_enable}, 24'(f != 2));
      chk("aux_hys_wide", {23'h0, aux_hys_wide}, 24'(f == 1));
    end
    // with both filter stages bypassed the sample passes unchanged, padded to 16 bits
    wr(MPPC_OFF_AUXPWR, 24'h000200);
    repeat (20) @(posedge mclk);
    #1;
    chk("aux_result", {8'h00, aux_result}, 24'h00ABC0);
    // dac setup: 01 pulses for one cycle, a reserved value does not
    wr(MPPC_OFF_DACSET, 24'h000001);
    #1;
    chk("dac_init_pulse", {23'h0, dac_init_pulse}, 24'h1);
    @(posedge mclk);
    #1;
    chk("dac_init_pulse end", {23'h0, dac_init_pulse}, 24'h0);
    wr(MPPC_OFF_DACSET, 24'h000002);
    #1;
    chk("dac_init_pulse reserved", {23'h0, dac_init_pulse}, 24'h0);
    // every pin code on one pin of each register; the other pins stay debounced inputs
    for (int k = 0; k < 2; k++) begin
      p = (k == 0) ? 3 : 8;
      a = (p < 6) ? MPPC_OFF_PIN_LO : MPPC_OFF_PIN_HI;
      sh = (p % 6) * 4;
      bit_p = 12'h001 << p;
      for (int n = 0; n < 16; n++) begin
        c = 4'(n);
        inv = c[3];
        is_in = (c == 4'h0) || (c == 4'h1) || (c == 4'h8) || (c == 4'h9);
        ser = (c == 4'h4) || (c == 4'hC);
        pp = (c == 4'h2) || (c == 4'hA);
        oc = (c == 4'h3) || (c == 4'hB);
        wr(a, 24'(c) << sh);
        // long enough for the synchroniser and the 16-cycle debounce
        repeat (30) @(posedge mclk);
        #1;
        chk("pull_up_en", {12'h0, pull_up_en}, {12'h0, (is_in | ser) ? 12'hFFF : ~bit_p});
        chk("pin_oe", {12'h0, pin_oe}, {12'h0, (pp | (oc & inv)) ? bit_p : 12'h000});
        chk("aux_sel", {12'h0, aux_sel}, {12'h0, (c == 4'hF) ? bit_p : 12'h000});
        chk("serial_in", {23'h0, serial_in[p]}, {23'h0, ser & ~inv});
        if (pp) begin
          chk("pin_out", {23'h0, pin_out[p]}, {23'h0, ~inv});
        end
        if (is_in) begin
          chk("core_in", {23'h0, core_in[p]}, {23'h0, ~inv});
        end
        rd(a, 24'(c) << sh);
      end
      wr(a, 24'h000000);
    end
    // raw input follows within a few cycles, debounced input waits out the filter
    wr(MPPC_OFF_PIN_LO, 24'h000010);
    repeat (30) @(posedge mclk);
    pin_in <= 12'hFFC;
    repeat (8) @(posedge mclk);
    #1;
    chk("core_in raw", {22'h0, core_in[1:0]}, 24'h000001);
    repeat (30) @(posedge mclk);
    #1;
    chk("core_in debounced", {22'h0, core_in[1:0]}, 24'h000000);
    // write then read with no gap between the strobes
    @(posedge mclk);
    reg_addr <= MPPC_OFF_PIN_LO;
    reg_wdata <= 24'h123456;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata back to back", reg_rdata, 24'h123456);
    print_verdict();
  end
endmodule
`default_nettype wire
